// File: hie_pkg.sv
// Constants and types for the image histogram enhancer
package hie_pkg;
    // Register byte addresses
    localparam logic [19:0] HIE_CTL_ADDR  = 20'h48260;
    localparam logic [19:0] HIE_BIN_ADDR  = 20'h48264;
    localparam logic [19:0] HIE_GB_ADDR   = 20'h48268;
    // Control register fields
    localparam int HIE_CTL_HIST_EN = 31;
    localparam int HIE_CTL_TBL_EN  = 30;
    localparam int HIE_CTL_PIPE    = 29;
    localparam int HIE_CTL_MEAS    = 24;
    localparam int HIE_CTL_PH_LO   = 16;
    localparam int HIE_CTL_MODE_LO = 13;
    localparam int HIE_CTL_FUNC    = 11;
    localparam int HIE_CTL_IDX_LO  = 0;
    localparam logic [31:0] HIE_CTL_WMASK = 32'he1ff683f;
    localparam logic [31:0] HIE_CTL_RST   = 32'h00000000;
    // Guardband register fields
    localparam int HIE_GB_IE     = 31;
    localparam int HIE_GB_ST     = 30;
    localparam int HIE_GB_DLY_LO = 22;
    localparam int HIE_GB_W      = 30;
    localparam logic [HIE_GB_W-1:0] HIE_GB_RST = 30'h00000000;
    // Bin data register fields
    localparam int HIE_BIN_BUSY = 31;
    // Sizes
    localparam int HIE_NBINS  = 32;
    localparam int HIE_NCORR  = 33;
    localparam int HIE_CNT_W  = 22;
    localparam int HIE_PIX_W  = 8;
    localparam int HIE_BIN_W  = 5;
    localparam int HIE_CORR_W = 10;
    localparam int HIE_IDX_W  = 6;
    localparam int HIE_PH_W   = 8;
    localparam int HIE_DLY_W  = 8;
    localparam int HIE_MULT_SH = 9;
    localparam logic [HIE_CORR_W-1:0] HIE_CORR_RST = 10'h000;
    typedef enum logic [1:0] {
        HIE_DIRECT,
        HIE_ADDITIVE,
        HIE_MULTIPLY,
        HIE_RESERVED
    } hie_mode_e;
endpackage

// File: hie_dbuf.sv
// Double-buffered value: pending copy written by software, active copy loaded on an event
`timescale 1ns/1ns
module hie_dbuf
    import hie_pkg::*;
#(
    parameter int             W   = 10,
    parameter logic [W-1:0]   RST = '0
)(
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    // Write side
    input  wire logic         wr,
    input  wire logic [W-1:0] wdata,
    // Load event
    input  wire logic         load,
    // Values
    output logic      [W-1:0] pend,
    output logic      [W-1:0] act
);
    logic [W-1:0] pend_next;
    logic [W-1:0] act_next;

    always_comb begin
        pend_next = wr ? wdata : pend;
        // A write in the load cycle is not lost; it waits for the next load
        act_next  = load ? pend : act;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pend <= RST;
            act  <= RST;
        end else begin
            pend <= pend_next;
            act  <= act_next;
        end
    end
endmodule

// File: hie_bin_cnt.sv
// One histogram bin: frame counter, captured threshold count and guardband compare
`timescale 1ns/1ns
module hie_bin_cnt
    import hie_pkg::*;
(
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // Control
    input  wire logic                 hit,
    input  wire logic                 cap,
    input  wire logic [HIE_CNT_W-1:0] guard,
    // Results
    output logic      [HIE_CNT_W-1:0] thresh,
    output logic                      over
);
    logic [HIE_CNT_W-1:0] cnt_reg;
    logic [HIE_CNT_W-1:0] cnt_next;
    logic [HIE_CNT_W-1:0] thr_next;
    logic [HIE_CNT_W-1:0] diff;
    logic                 over_next;

    always_comb begin
        diff      = (cnt_reg > thresh) ? cnt_reg - thresh : thresh - cnt_reg;
        cnt_next  = cnt_reg;
        thr_next  = thresh;
        over_next = over;
        if (cap) begin
            cnt_next  = {{(HIE_CNT_W-1){1'b0}}, hit};
            thr_next  = cnt_reg;
            over_next = diff > guard;
        end else if (hit && !(&cnt_reg)) begin
            // Saturate rather than wrap on oversized frames
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_reg <= '0;
            thresh  <= '0;
            over    <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            thresh  <= thr_next;
            over    <= over_next;
        end
    end
endmodule

// File: hie_top.sv
// Image histogram enhancer: registers, histogram bins, guardband event and correction table
`timescale 1ns/1ns
module hie_top
    import hie_pkg::*;
(
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // Register access
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [19:0]          reg_addr,
    input  wire logic [31:0]          reg_wdata,
    output logic      [31:0]          reg_rdata,
    output logic                      reg_rvalid,
    // Pipe timing and phase-in
    input  wire logic                 vblank_a,
    input  wire logic                 vblank_b,
    input  wire logic                 phase_in_en,
    input  wire logic [HIE_PH_W-1:0]  phase_in_cnt,
    // Pixel stream
    input  wire logic                 pix_valid,
    input  wire logic [HIE_PIX_W-1:0] pix_luma,
    input  wire logic [HIE_PIX_W-1:0] pix_intensity,
    output logic                      out_valid,
    output logic      [HIE_PIX_W-1:0] out_pix,
    // Interrupt
    output logic                      hist_irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [31:0]           ctl_reg;
    logic [31:0]           ctl_next;
    logic                  ie_reg;
    logic                  ie_next;
    logic                  st_reg;
    logic                  st_next;
    logic                  vb_prev_reg;
    logic                  run_reg;
    logic                  run_next;
    logic                  valid_reg;
    logic                  valid_next;
    logic                  arm_reg;
    logic                  arm_next;
    logic                  cap_d_reg;
    logic [HIE_DLY_W-1:0]  frm_reg;
    logic [HIE_DLY_W-1:0]  frm_next;
    logic [31:0]           rd_next;
    logic [HIE_PIX_W-1:0]  pix_next;
    logic                  vb_sel;
    logic                  vb_edge;
    logic                  cap;
    logic                  corr_load;
    logic                  evt;
    logic                  wr_ctl;
    logic                  wr_bin;
    logic                  wr_gb;
    logic                  func;
    logic                  busy;
    logic [HIE_IDX_W-1:0]  idx;
    logic [HIE_DLY_W-1:0]  dly;
    hie_mode_e             mode;
    logic [HIE_PIX_W-1:0]  meas;
    logic [HIE_BIN_W-1:0]  pix_bin;
    logic [HIE_GB_W-1:0]   gb_pend;
    logic [HIE_GB_W-1:0]   gb_act;
    logic [HIE_NBINS-1:0]  over;
    logic [HIE_CNT_W-1:0]  thresh    [HIE_NBINS];
    logic [HIE_CORR_W-1:0] corr_pend [HIE_NCORR];
    logic [HIE_CORR_W-1:0] corr_act  [HIE_NCORR];
    logic [HIE_CORR_W-1:0] corr;
    logic [HIE_PIX_W:0]    sum;
    logic [HIE_PIX_W+HIE_CORR_W-1:0] prod;

    ////////////////////////////////////////////////////////////////////////////
    // Decode and field views
    assign wr_ctl = reg_wr && reg_addr == HIE_CTL_ADDR;
    assign wr_bin = reg_wr && reg_addr == HIE_BIN_ADDR;
    assign wr_gb  = reg_wr && reg_addr == HIE_GB_ADDR;
    assign func   = ctl_reg[HIE_CTL_FUNC];
    assign idx    = ctl_reg[HIE_CTL_IDX_LO +: HIE_IDX_W];
    assign mode   = hie_mode_e'(ctl_reg[HIE_CTL_MODE_LO +: 2]);
    assign dly    = gb_act[HIE_GB_DLY_LO +: HIE_DLY_W];
    // Events follow the assigned pipe, so a pipe change while enabled glitches timing
    assign vb_sel = ctl_reg[HIE_CTL_PIPE] ? vblank_b : vblank_a;
    assign vb_edge = vb_sel && !vb_prev_reg;
    assign cap    = vb_edge && run_reg;
    assign busy   = ctl_reg[HIE_CTL_HIST_EN] && !valid_reg;
    assign corr_load = vb_edge
        && (!phase_in_en || phase_in_cnt == ctl_reg[HIE_CTL_PH_LO +: HIE_PH_W]);
    assign meas   = ctl_reg[HIE_CTL_MEAS] ? pix_intensity : pix_luma;
    assign pix_bin = meas[HIE_PIX_W-1 -: HIE_BIN_W];
    assign evt    = cap_d_reg && (|over) && dly != '0
        && frm_reg + 1'b1 == dly;

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    hie_dbuf #(
        .W   (HIE_GB_W),
        .RST (HIE_GB_RST)
    ) u_gb (
        .core_clk (core_clk),
        .rst      (rst),
        .wr       (wr_gb),
        .wdata    (reg_wdata[HIE_GB_W-1:0]),
        .load     (vb_edge),
        .pend     (gb_pend),
        .act      (gb_act)
    );

    for (genvar i = 0; i < HIE_NCORR; i++) begin : g_corr
        hie_dbuf #(
            .W   (HIE_CORR_W),
            .RST (HIE_CORR_RST)
        ) u_corr (
            .core_clk (core_clk),
            .rst      (rst),
            .wr       (wr_bin && func && idx == HIE_IDX_W'(i)),
            .wdata    (reg_wdata[HIE_CORR_W-1:0]),
            .load     (corr_load),
            .pend     (corr_pend[i]),
            .act      (corr_act[i])
        );
    end

    for (genvar i = 0; i < HIE_NBINS; i++) begin : g_bin
        hie_bin_cnt u_bin (
            .core_clk (core_clk),
            .rst      (rst),
            .hit      (run_reg && pix_valid && pix_bin == HIE_BIN_W'(i)),
            .cap      (cap),
            .guard    (gb_act[HIE_CNT_W-1:0]),
            .thresh   (thresh[i]),
            .over     (over[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control state
    always_comb begin
        ctl_next = ctl_reg;
        if (wr_ctl) begin
            ctl_next = reg_wdata & HIE_CTL_WMASK;
        end
        ie_next = wr_gb ? reg_wdata[HIE_GB_IE] : ie_reg;
        st_next = st_reg;
        if (wr_gb && reg_wdata[HIE_GB_ST]) begin
            st_next = 1'b0;
        end
        if (evt) begin
            st_next = 1'b1;
        end
        run_next   = ctl_reg[HIE_CTL_HIST_EN] && (run_reg || vb_edge);
        valid_next = ctl_reg[HIE_CTL_HIST_EN] && (valid_reg || cap);
        arm_next   = ctl_reg[HIE_CTL_TBL_EN] && (arm_reg || vb_edge);
        frm_next   = frm_reg;
        if (!run_reg) begin
            frm_next = '0;
        end else if (cap_d_reg) begin
            if (!(|over)) begin
                frm_next = '0;
            end else if (!(&frm_reg)) begin
                frm_next = frm_reg + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path
    always_comb begin
        rd_next = '0;
        if (reg_addr == HIE_CTL_ADDR) begin
            rd_next = ctl_reg;
        end else if (reg_addr == HIE_BIN_ADDR) begin
            if (!func) begin
                if (busy) begin
                    rd_next[HIE_BIN_BUSY] = 1'b1;
                end else if (idx < HIE_IDX_W'(HIE_NBINS)) begin
                    rd_next[HIE_CNT_W-1:0] = thresh[idx[HIE_BIN_W-1:0]];
                end
            end else if (idx < HIE_IDX_W'(HIE_NCORR)) begin
                rd_next[HIE_CORR_W-1:0] = corr_pend[idx];
            end
        end else if (reg_addr == HIE_GB_ADDR) begin
            rd_next = {ie_reg, st_reg, gb_pend};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pixel correction
    always_comb begin
        corr     = corr_act[pix_bin];
        sum      = {1'b0, meas} + {1'b0, corr[HIE_CORR_W-1 -: HIE_PIX_W]};
        prod     = meas * corr;
        pix_next = meas;
        if (arm_reg) begin
            case (mode)
                HIE_DIRECT: begin
                    pix_next = corr[HIE_CORR_W-1 -: HIE_PIX_W];
                end
                HIE_ADDITIVE: begin
                    pix_next = sum[HIE_PIX_W] ? '1 : sum[HIE_PIX_W-1:0];
                end
                HIE_MULTIPLY: begin
                    // Correction of 512 is unity gain; results saturate
                    pix_next = (|prod[HIE_PIX_W+HIE_CORR_W-1:HIE_PIX_W+HIE_MULT_SH]) ? '1
                        : prod[HIE_MULT_SH +: HIE_PIX_W];
                end
                default: begin
                    pix_next = meas;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctl_reg     <= HIE_CTL_RST;
            ie_reg      <= 1'b0;
            st_reg      <= 1'b0;
            vb_prev_reg <= 1'b0;
            run_reg     <= 1'b0;
            valid_reg   <= 1'b0;
            arm_reg     <= 1'b0;
            cap_d_reg   <= 1'b0;
            frm_reg     <= '0;
            reg_rdata   <= '0;
            reg_rvalid  <= 1'b0;
            out_valid   <= 1'b0;
            out_pix     <= '0;
            hist_irq    <= 1'b0;
        end else begin
            ctl_reg     <= ctl_next;
            ie_reg      <= ie_next;
            st_reg      <= st_next;
            vb_prev_reg <= vb_sel;
            run_reg     <= run_next;
            valid_reg   <= valid_next;
            arm_reg     <= arm_next;
            cap_d_reg   <= cap;
            frm_reg     <= frm_next;
            reg_rdata   <= reg_rd ? rd_next : '0;
            reg_rvalid  <= reg_rd;
            out_valid   <= pix_valid;
            out_pix     <= pix_next;
            hist_irq    <= ie_next && st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_irq_gate: assert property (hist_irq == (ie_reg && st_reg))
        else $error("interrupt differs from enable and flag");
    a_irq_raise: assert property (evt && ie_reg && !wr_gb |=> hist_irq)
        else $error("event did not raise interrupt");
    a_evt_sets: assert property (evt |=> st_reg)
        else $error("event flag not set");
    a_w1c_clear: assert property (wr_gb && reg_wdata[HIE_GB_ST] && !evt |=> !st_reg)
        else $error("write one did not clear flag");
    a_flag_sticky: assert property (st_reg && !wr_gb |=> st_reg)
        else $error("flag dropped without clear");
    a_evt_delay: assert property (evt |-> dly != '0 && frm_reg == dly - 1'b1)
        else $error("event before delay frames");
    a_gb_load: assert property (vb_edge |=> gb_act == $past(gb_pend))
        else $error("guardband not loaded at vblank");
    a_corr_hold: assert property (!corr_load |=> $stable(corr_act[0]))
        else $error("correction changed outside load");
    a_hist_start: assert property ($rose(ctl_reg[HIE_CTL_HIST_EN]) && !vb_edge |=> !run_reg)
        else $error("histogram started before vblank");
    a_busy_read: assert property (reg_rd && reg_addr == HIE_BIN_ADDR && !func && busy
        |=> reg_rvalid && reg_rdata == 32'h80000000)
        else $error("busy read did not show bit 31");
    a_rsvd_zero: assert property (reg_rvalid && $past(reg_addr) == HIE_CTL_ADDR
        |-> (reg_rdata & ~HIE_CTL_WMASK) == '0)
        else $error("reserved control bits nonzero");
    // A vblank capture may land in the same cycle as the ignored write
    a_ro_thresh: assert property (wr_bin && !func
        |=> $stable(corr_pend[0]) && ($past(cap) || $stable(thresh[0])))
        else $error("threshold function write had an effect");

    c_event: cover property (evt ##1 hist_irq);
    c_busy_read: cover property (reg_rd && reg_addr == HIE_BIN_ADDR && busy);
    c_corr_load: cover property (corr_load && phase_in_en);
    c_mult_out: cover property (arm_reg && mode == HIE_MULTIPLY && pix_valid);
endmodule

// File: hie_pipe_model.sv
// Display pipe model: pixel stream and vertical blank of the assigned pipe
`timescale 1ns/1ns
module hie_pipe_model
    import hie_pkg::*;
(
    // Clock and frame request
    input  wire logic                 core_clk,
    input  wire logic                 go,
    input  wire logic [7:0]           npix,
    input  wire logic [HIE_PIX_W-1:0] pval,
    input  wire logic                 with_vb,
    input  wire logic                 sel_b,
    // Pipe side
    output logic                      vblank_a,
    output logic                      vblank_b,
    output logic                      pix_valid,
    output logic      [HIE_PIX_W-1:0] pix_luma,
    output logic      [HIE_PIX_W-1:0] pix_intensity,
    output logic                      done
);
    initial begin
        vblank_a = 1'b0;
        vblank_b = 1'b0;
        pix_valid = 1'b0;
        pix_luma = 8'h5a;
        pix_intensity = 8'ha5;
        done = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        done <= 1'b0;
        if (go === 1'b1) begin
            for (int i = 0; i < npix; i++) begin
                pix_valid <= 1'b1;
                pix_luma <= pval;
                pix_intensity <= ~pval;
                @(posedge core_clk);
            end
            // Idle lines show the inverse so a stale pixel is never read as valid
            pix_valid <= 1'b0;
            pix_luma <= ~pix_luma;
            pix_intensity <= ~pix_intensity;
            if (with_vb) begin
                vblank_a <= ~sel_b;
                vblank_b <= sel_b;
                repeat (4) @(posedge core_clk);
                vblank_a <= 1'b0;
                vblank_b <= 1'b0;
            end
            repeat (4) @(posedge core_clk);
            done <= 1'b1;
        end
    end
endmodule

// File: testbench.sv
// Self-checking bench for the image histogram enhancer
`timescale 1ns/1ns
module testbench;
    import hie_pkg::*;

    logic        core_clk    = 1'b0;
    logic        rst         = 1'b1;
    logic        reg_wr      = 1'b0;
    logic        reg_rd      = 1'b0;
    logic [19:0] reg_addr    = 20'h00000;
    logic [31:0] reg_wdata   = 32'h00000000;
    logic [31:0] reg_rdata;
    logic        reg_rvalid, vblank_a, vblank_b, pix_valid, out_valid, hist_irq, done;
    logic        ph_en       = 1'b0;
    logic [7:0]  ph_cnt      = 8'h00;
    logic        go          = 1'b0;
    logic [7:0]  npix        = 8'h00;
    logic [7:0]  pval        = 8'h00;
    logic        with_vb     = 1'b0;
    logic        sel_b       = 1'b0;
    logic [7:0]  pix_luma, pix_intensity, out_pix, last_out;
    int          n_mismatch  = 0;
    int          checks_done = 0;
    int          n_out       = 0;

    always #25 core_clk = ~core_clk;

    hie_top dut_u (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .vblank_a(vblank_a),
        .vblank_b(vblank_b), .phase_in_en(ph_en), .phase_in_cnt(ph_cnt), .pix_valid(pix_valid),
        .pix_luma(pix_luma), .pix_intensity(pix_intensity), .out_valid(out_valid), .out_pix(out_pix),
        .hist_irq(hist_irq));

    hie_pipe_model pipe_u (.core_clk(core_clk), .go(go), .npix(npix), .pval(pval), .with_vb(with_vb),
        .sel_b(sel_b), .vblank_a(vblank_a), .vblank_b(vblank_b), .pix_valid(pix_valid),
        .pix_luma(pix_luma), .pix_intensity(pix_intensity), .done(done));

    always @(posedge core_clk) begin
        if (out_valid === 1'b1) begin
            last_out <= out_pix;
            n_out <= n_out + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("Counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [19:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk({31'h0, reg_rvalid}, 32'h1);
        chk(reg_rdata, exp);
    endtask

    task automatic frame(input logic [7:0] n, input logic [7:0] p, input logic vb);
        int k;
        @(posedge core_clk);
        go <= 1'b1;
        npix <= n;
        pval <= p;
        with_vb <= vb;
        @(posedge core_clk);
        go <= 1'b0;
        for (k = 0; k < 300 && done !== 1'b1; k++) begin
            @(posedge core_clk);
            #1;
        end
        if (done !== 1'b1) begin
            n_mismatch++;
            $display("BAD at %0t: frame got %h expected %h", $time, 1'b0, 1'b1);
            end_sim();
        end
    endtask

    task automatic pix(input logic [7:0] p, input logic [7:0] e);
        int n0;
        n0 = n_out;
        frame(8'h01, p, 1'b0);
        chk(n_out - n0, 32'h00000001);
        chk({24'h0, last_out}, {24'h0, e});
    endtask

    task automatic irq_is(input logic e);
        chk({31'h0, hist_irq}, {31'h0, e});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(HIE_CTL_ADDR, HIE_CTL_RST);
        rd(HIE_GB_ADDR, 32'h00000000);
        rd(HIE_BIN_ADDR, 32'h00000000);
        rd(20'h4826c, 32'h00000000);
        irq_is(1'b0);
        $display("test reset done");
    endtask

    task automatic t_ctl();
        // Pipe bit stays 0 so the assignment never moves while enabled
        wr(HIE_CTL_ADDR, 32'hdfffffff);
        rd(HIE_CTL_ADDR, HIE_CTL_WMASK & 32'hdfffffff);
        for (int m = 0; m < 4; m++) begin
            wr(HIE_CTL_ADDR, (32'(m) << HIE_CTL_MODE_LO) | 32'h01000000);
            rd(HIE_CTL_ADDR, (32'(m) << HIE_CTL_MODE_LO) | 32'h01000000);
        end
        wr(HIE_CTL_ADDR, 32'h00000000);
        $display("test control done");
    endtask

    task automatic t_corr();
        wr(HIE_CTL_ADDR, 32'h00000820);
        wr(HIE_BIN_ADDR, 32'hffffffff);
        rd(HIE_BIN_ADDR, 32'h000003ff);
        wr(HIE_CTL_ADDR, 32'h00000821);
        wr(HIE_BIN_ADDR, 32'h00000155);
        rd(HIE_BIN_ADDR, 32'h00000000);
        wr(HIE_CTL_ADDR, 32'h00000005);
        wr(HIE_BIN_ADDR, 32'h00000123);
        rd(HIE_BIN_ADDR, 32'h00000000);
        wr(HIE_CTL_ADDR, 32'h00000805);
        rd(HIE_BIN_ADDR, 32'h00000000);
        $display("test correction done");
    endtask

    task automatic t_hist();
        wr(HIE_CTL_ADDR, 32'h80000005);
        rd(HIE_BIN_ADDR, 32'h80000000);
        frame(8'h0a, 8'h2c, 1'b1);
        frame(8'h06, 8'h2c, 1'b1);
        rd(HIE_BIN_ADDR, 32'h00000006);
        wr(HIE_CTL_ADDR, 32'h80000020);
        rd(HIE_BIN_ADDR, 32'h00000000);
        wr(HIE_CTL_ADDR, 32'h8100001a);
        frame(8'h03, 8'h2c, 1'b1);
        rd(HIE_BIN_ADDR, 32'h00000003);
        $display("test histogram done");
    endtask

    task automatic t_guard();
        // Empty frames settle the counts so each later difference is known
        frame(8'h00, 8'h2c, 1'b1);
        frame(8'h00, 8'h2c, 1'b1);
        wr(HIE_GB_ADDR, 32'h80800000);
        rd(HIE_GB_ADDR, 32'h80800000);
        frame(8'h00, 8'h2c, 1'b1);
        frame(8'h04, 8'h2c, 1'b1);
        irq_is(1'b0);
        frame(8'h08, 8'h2c, 1'b1);
        irq_is(1'b1);
        rd(HIE_GB_ADDR, 32'hc0800000);
        wr(HIE_GB_ADDR, 32'hc0800000);
        @(posedge core_clk);
        #1;
        irq_is(1'b0);
        rd(HIE_GB_ADDR, 32'h80800000);
        frame(8'h08, 8'h2c, 1'b1);
        irq_is(1'b0);
        wr(HIE_GB_ADDR, 32'h80800008);
        frame(8'h00, 8'h2c, 1'b1);
        frame(8'h08, 8'h2c, 1'b1);
        irq_is(1'b0);
        $display("test guardband done");
    endtask

    task automatic t_table();
        logic [7:0] exp_out [4] = '{8'haa, 8'hd6, 8'h3a, 8'h2c};
        wr(HIE_CTL_ADDR, 32'h00000805);
        wr(HIE_BIN_ADDR, 32'h000002a8);
        wr(HIE_CTL_ADDR, 32'h40000805);
        pix(8'h2c, 8'h2c);
        frame(8'h00, 8'h2c, 1'b1);
        for (int m = 0; m < 4; m++) begin
            wr(HIE_CTL_ADDR, 32'h40000805 | (32'(m) << HIE_CTL_MODE_LO));
            pix(8'h2c, exp_out[m]);
        end
        wr(HIE_CTL_ADDR, 32'h40050805);
        ph_cnt <= 8'h03;
        ph_en <= 1'b1;
        wr(HIE_BIN_ADDR, 32'h00000100);
        frame(8'h00, 8'h2c, 1'b1);
        pix(8'h2c, 8'haa);
        @(posedge core_clk);
        ph_cnt <= 8'h05;
        frame(8'h00, 8'h2c, 1'b1);
        pix(8'h2c, 8'h40);
        $display("test table done");
    endtask

    task automatic t_pipe();
        // Table is switched on in the same write that moves the pipe assignment
        wr(HIE_CTL_ADDR, 32'h00000805);
        ph_en <= 1'b0;
        wr(HIE_BIN_ADDR, 32'h00000200);
        wr(HIE_CTL_ADDR, 32'h60000805);
        frame(8'h00, 8'h2c, 1'b1);
        pix(8'h2c, 8'h2c);
        @(posedge core_clk);
        sel_b <= 1'b1;
        frame(8'h00, 8'h2c, 1'b1);
        pix(8'h2c, 8'h80);
        $display("test pipe done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_ctl();
        t_corr();
        t_hist();
        t_guard();
        t_table();
        t_pipe();
        end_sim();
    end
endmodule
